//--- opdec_pkg.sv
// Constants, codes and enumerations shared by the opcode decode and timing block.
package opdec_pkg;

    // Field widths.
    localparam int CYC_W = 4;
    localparam int LEN_W = 2;
    localparam int BIT_W = 3;

    // Opcode high nibbles that select the instruction group and operand form.
    localparam logic [3:0] HI_BIT_TEST = 4'h0;
    localparam logic [3:0] HI_BIT_SET = 4'h1;
    localparam logic [3:0] HI_BRANCH = 4'h2;
    localparam logic [3:0] HI_RMW_DIRECT = 4'h3;
    localparam logic [3:0] HI_RMW_ACC = 4'h4;
    localparam logic [3:0] HI_RMW_INDEX = 4'h5;
    localparam logic [3:0] HI_RMW_IX1 = 4'h6;
    localparam logic [3:0] HI_RMW_IX = 4'h7;

    // Read/modify/write low nibbles.
    localparam logic [3:0] LO_NEGATE = 4'h0;
    localparam logic [3:0] LO_MULT = 4'h2;
    localparam logic [3:0] LO_INVERT = 4'h3;
    localparam logic [3:0] LO_SHR = 4'h4;
    localparam logic [3:0] LO_ROTR = 4'h6;
    localparam logic [3:0] LO_SAR = 4'h7;
    localparam logic [3:0] LO_SHL = 4'h8;
    localparam logic [3:0] LO_ROTL = 4'h9;
    localparam logic [3:0] LO_DECR = 4'ha;
    localparam logic [3:0] LO_INC = 4'hc;
    localparam logic [3:0] LO_TEST = 4'hd;
    localparam logic [3:0] LO_ZERO = 4'hf;

    // Relative branch low nibbles.
    localparam logic [3:0] BR_ALWAYS = 4'h0;
    localparam logic [3:0] BR_NEVER = 4'h1;
    localparam logic [3:0] BR_HIGHER = 4'h2;
    localparam logic [3:0] BR_LOWER_SAME = 4'h3;
    localparam logic [3:0] BR_CARRY_CLEAR = 4'h4;
    localparam logic [3:0] BR_CARRY_SET = 4'h5;
    localparam logic [3:0] BR_NOT_EQUAL = 4'h6;
    localparam logic [3:0] BR_EQUAL = 4'h7;
    localparam logic [3:0] BR_HALF_CLEAR = 4'h8;
    localparam logic [3:0] BR_HALF_SET = 4'h9;
    localparam logic [3:0] BR_PLUS = 4'ha;
    localparam logic [3:0] BR_MINUS = 4'hb;
    localparam logic [3:0] BR_MASK_CLEAR = 4'hc;
    localparam logic [3:0] BR_MASK_SET = 4'hd;
    localparam logic [3:0] BR_IRQ_LOW = 4'he;
    localparam logic [3:0] BR_IRQ_HIGH = 4'hf;

    // Whole opcodes of the control and call instructions.
    localparam logic [7:0] OP_IRET = 8'h80;
    localparam logic [7:0] OP_RTS = 8'h81;
    localparam logic [7:0] OP_TRAP = 8'h83;
    localparam logic [7:0] OP_STOP = 8'h8e;
    localparam logic [7:0] OP_WAIT = 8'h8f;
    localparam logic [7:0] OP_A2X = 8'h97;
    localparam logic [7:0] OP_CCLR = 8'h98;
    localparam logic [7:0] OP_CSET = 8'h99;
    localparam logic [7:0] OP_MCLR = 8'h9a;
    localparam logic [7:0] OP_MSET = 8'h9b;
    localparam logic [7:0] OP_SPRST = 8'h9c;
    localparam logic [7:0] OP_IDLE = 8'h9d;
    localparam logic [7:0] OP_X2A = 8'h9f;
    localparam logic [7:0] OP_CALL = 8'had;

    // Instruction lengths in bytes.
    localparam logic [LEN_W-1:0] LEN_NONE = 2'h0;
    localparam logic [LEN_W-1:0] LEN_1 = 2'h1;
    localparam logic [LEN_W-1:0] LEN_2 = 2'h2;
    localparam logic [LEN_W-1:0] LEN_3 = 2'h3;

    // Execution lengths in CPU cycles.
    localparam logic [CYC_W-1:0] CYC_NONE = 4'h0;
    localparam logic [CYC_W-1:0] CYC_ONE = 4'h1;
    localparam logic [CYC_W-1:0] CYC_INH = 4'h2;
    localparam logic [CYC_W-1:0] CYC_BRANCH = 4'h3;
    localparam logic [CYC_W-1:0] CYC_RMW_REG = 4'h3;
    localparam logic [CYC_W-1:0] CYC_BIT = 4'h5;
    localparam logic [CYC_W-1:0] CYC_RMW_DIR = 4'h5;
    localparam logic [CYC_W-1:0] CYC_RMW_IX = 4'h5;
    localparam logic [CYC_W-1:0] CYC_RMW_IX1 = 4'h6;
    localparam logic [CYC_W-1:0] CYC_RTS = 4'h6;
    localparam logic [CYC_W-1:0] CYC_CALL = 4'h6;
    localparam logic [CYC_W-1:0] CYC_IRET = 4'h9;
    localparam logic [CYC_W-1:0] CYC_TRAP = 4'ha;
    localparam logic [CYC_W-1:0] CYC_MULT = 4'hb;
    localparam logic [CYC_W-1:0] TEST_SAVING = 4'h1;

    typedef enum logic [2:0] {
        GRP_NONE = 3'h0,
        GRP_BRANCH = 3'h1,
        GRP_BIT_TEST = 3'h2,
        GRP_BIT_SET = 3'h3,
        GRP_RMW = 3'h4,
        GRP_MULT = 3'h5,
        GRP_CONTROL = 3'h6,
        GRP_CALL = 3'h7
    } group_t;

    typedef enum logic [2:0] {
        MODE_NONE = 3'h0,
        MODE_ACC = 3'h1,
        MODE_INDEX = 3'h2,
        MODE_DIRECT = 3'h3,
        MODE_IX = 3'h4,
        MODE_IX1 = 3'h5,
        MODE_REL = 3'h6
    } operand_mode_t;

    typedef enum logic [3:0] {
        alu_none = 4'h0,
        negate_op = 4'h1,
        complement_op = 4'h2,
        logical_shift_right_op = 4'h3,
        rotate_right_op = 4'h4,
        arith_shift_right_op = 4'h5,
        shift_left_op = 4'h6,
        rotate_left_op = 4'h7,
        decrement_op = 4'h8,
        increment_op = 4'h9,
        test_value_op = 4'ha,
        clear_op = 4'hb,
        multiply_op = 4'hc
    } alu_op_t;

    typedef enum logic [3:0] {
        ctrl_none = 4'h0,
        acc_to_index_op = 4'h1,
        index_to_acc_op = 4'h2,
        set_carry_op = 4'h3,
        clear_carry_op = 4'h4,
        set_mask_op = 4'h5,
        clear_mask_op = 4'h6,
        soft_interrupt_op = 4'h7,
        subroutine_return_op = 4'h8,
        interrupt_return_op = 4'h9,
        stack_pointer_reset_op = 4'ha,
        no_operation_op = 4'hb,
        stop_op = 4'hc,
        wait_op = 4'hd
    } ctrl_op_t;

endpackage

//--- cycle_counter.sv
// Down counter that paces one instruction through its execution cycles.
`timescale 1ns/10ps
`default_nettype none
module cycle_counter #(
    parameter int WIDTH = 4
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic idle,
    output logic last
);
    typedef struct packed {
        logic [WIDTH-1:0] remaining;
    } count_state_t;

    count_state_t cur;
    count_state_t next_cur;

    // Load on a new instruction, otherwise count down to zero.
    always_comb begin
        next_cur = cur;
        if (load) begin
            next_cur.remaining = load_value;
        end else if (cur.remaining != '0) begin
            next_cur.remaining = cur.remaining - WIDTH'(1);
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Idle means a new opcode may be taken; last marks the final cycle.
    assign idle = (cur.remaining == '0);
    assign last = (cur.remaining == WIDTH'(1));
endmodule
`default_nettype wire

//--- opcode_decode.sv
// Opcode decoder and execution timing sequencer for the 8-bit CPU core.
//
// Overview of operation
// (RULE_01) Opcodes 20,21,22,23,26,27,2A,2B are two-byte branches of three cycles.
// (RULE_02) Opcode 24 branches on carry clear, 25 on carry set.
// (RULE_03) Opcode 28 branches on half-carry clear, 29 on set; two bytes, three cycles.
// (RULE_04) Opcode 2C branches on mask clear, 2D on mask set; two bytes, three cycles.
// (RULE_05) Opcode 2E branches on interrupt line low, 2F on high; two bytes, three cycles.
// (RULE_06) Opcode 2n branches if direct bit n set, 2n+1 if clear; 3 bytes, 5 cycles.
// (RULE_07) Opcode 10+2n sets direct bit n, 11+2n clears it; 2 bytes, 5 cycles.
// (RULE_08) High nibble picks operand: A, X, direct, indexed, indexed with 8-bit offset.
// (RULE_09) Low nibble picks the read/modify/write operation.
// (RULE_10) Test operation takes one cycle less in memory modes: 3,3,4,4,5.
// (RULE_11) One-byte inherent control opcodes other than those of RULE_12 each take two cycles.
// (RULE_12) Software interrupt takes 10, subroutine return 6, interrupt return 9 cycles.
// (RULE_13) Multiply forms the 16-bit index times accumulator product in 11 cycles.
// (RULE_14) Relative call pushes the return address; two bytes, six cycles.
`timescale 1ns/10ps
`default_nettype none
module opcode_decode (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic OPCODE_VALID,
    input wire logic [7:0] OPCODE,
    input wire logic FLAG_H,
    input wire logic FLAG_I,
    input wire logic FLAG_N,
    input wire logic FLAG_Z,
    input wire logic FLAG_C,
    input wire logic IRQ_LINE,
    input wire logic TEST_BYTE_VALID,
    input wire logic [7:0] TEST_BYTE,
    input wire logic [7:0] INDEX_IN,
    input wire logic [7:0] ACC_IN,
    output logic READY,
    output logic DONE,
    output logic ILLEGAL,
    output logic [opdec_pkg::LEN_W-1:0] INSTR_BYTES,
    output logic [opdec_pkg::CYC_W-1:0] INSTR_CYCLES,
    output var opdec_pkg::group_t GROUP,
    output var opdec_pkg::alu_op_t ALU_OP,
    output var opdec_pkg::ctrl_op_t CTRL_OP,
    output var opdec_pkg::operand_mode_t OPERAND_MODE,
    output logic [opdec_pkg::BIT_W-1:0] BIT_INDEX,
    output logic BIT_VALUE,
    output logic BRANCH_TAKEN,
    output logic PUSH_RETURN,
    output logic [15:0] PRODUCT
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic illegal;
        logic [opdec_pkg::LEN_W-1:0] bytes;
        logic [opdec_pkg::CYC_W-1:0] cycles;
        opdec_pkg::group_t group;
        opdec_pkg::alu_op_t alu_op;
        opdec_pkg::ctrl_op_t ctrl_op;
        opdec_pkg::operand_mode_t mode;
        logic [opdec_pkg::BIT_W-1:0] bit_index;
        logic bit_value;
        logic taken;
        logic push_return;
        logic [15:0] product;
    } decode_state_t;

    decode_state_t cur;
    decode_state_t next_cur;

    logic accept;
    logic counter_idle;
    logic counter_last;
    logic [3:0] hi;
    logic [3:0] lo;
    logic d_legal;
    logic [opdec_pkg::LEN_W-1:0] d_bytes;
    logic [opdec_pkg::CYC_W-1:0] d_cycles;
    opdec_pkg::group_t d_group;
    opdec_pkg::alu_op_t d_alu;
    opdec_pkg::ctrl_op_t d_ctrl;
    opdec_pkg::operand_mode_t d_mode;
    logic d_cond;
    logic [opdec_pkg::CYC_W-1:0] load_value;

    assign hi = OPCODE[7:4];
    assign lo = OPCODE[3:0];
    assign accept = OPCODE_VALID && counter_idle;

    // Branch condition of a relative branch, from the flags at the time of decode.
    always_comb begin
        case (lo)
            opdec_pkg::BR_ALWAYS: d_cond = 1'b1; // RULE_01
            opdec_pkg::BR_NEVER: d_cond = 1'b0; // RULE_01
            opdec_pkg::BR_HIGHER: d_cond = !(FLAG_C || FLAG_Z); // RULE_01
            opdec_pkg::BR_LOWER_SAME: d_cond = FLAG_C || FLAG_Z; // RULE_01
            opdec_pkg::BR_CARRY_CLEAR: d_cond = !FLAG_C; // RULE_02
            opdec_pkg::BR_CARRY_SET: d_cond = FLAG_C; // RULE_02
            opdec_pkg::BR_NOT_EQUAL: d_cond = !FLAG_Z; // RULE_01
            opdec_pkg::BR_EQUAL: d_cond = FLAG_Z; // RULE_01
            opdec_pkg::BR_HALF_CLEAR: d_cond = !FLAG_H; // RULE_03
            opdec_pkg::BR_HALF_SET: d_cond = FLAG_H; // RULE_03
            opdec_pkg::BR_PLUS: d_cond = !FLAG_N; // RULE_01
            opdec_pkg::BR_MINUS: d_cond = FLAG_N; // RULE_01
            opdec_pkg::BR_MASK_CLEAR: d_cond = !FLAG_I; // RULE_04
            opdec_pkg::BR_MASK_SET: d_cond = FLAG_I; // RULE_04
            opdec_pkg::BR_IRQ_LOW: d_cond = !IRQ_LINE; // RULE_05
            default: d_cond = IRQ_LINE; // RULE_05
        endcase
    end

    // Opcode classification into group, operation, operand form, length and timing.
    always_comb begin
        d_legal = 1'b1;
        d_bytes = opdec_pkg::LEN_1;
        d_cycles = opdec_pkg::CYC_INH;
        d_group = opdec_pkg::GRP_CONTROL;
        d_alu = opdec_pkg::alu_none;
        d_ctrl = opdec_pkg::ctrl_none;
        d_mode = opdec_pkg::MODE_NONE;
        if (hi == opdec_pkg::HI_BIT_TEST) begin
            d_group = opdec_pkg::GRP_BIT_TEST; // RULE_06
            d_mode = opdec_pkg::MODE_DIRECT;
            d_bytes = opdec_pkg::LEN_3; // RULE_06
            d_cycles = opdec_pkg::CYC_BIT; // RULE_06
        end else if (hi == opdec_pkg::HI_BIT_SET) begin
            d_group = opdec_pkg::GRP_BIT_SET; // RULE_07
            d_mode = opdec_pkg::MODE_DIRECT;
            d_bytes = opdec_pkg::LEN_2; // RULE_07
            d_cycles = opdec_pkg::CYC_BIT; // RULE_07
        end else if (hi == opdec_pkg::HI_BRANCH) begin
            d_group = opdec_pkg::GRP_BRANCH;
            d_mode = opdec_pkg::MODE_REL;
            d_bytes = opdec_pkg::LEN_2; // RULE_01
            d_cycles = opdec_pkg::CYC_BRANCH; // RULE_01
        end else if (OPCODE == {opdec_pkg::HI_RMW_ACC, opdec_pkg::LO_MULT}) begin
            d_group = opdec_pkg::GRP_MULT; // RULE_13
            d_alu = opdec_pkg::multiply_op;
            d_cycles = opdec_pkg::CYC_MULT; // RULE_13
        end else if (hi >= opdec_pkg::HI_RMW_DIRECT && hi <= opdec_pkg::HI_RMW_IX) begin
            d_group = opdec_pkg::GRP_RMW;
            // Operand form and its length and base timing.
            if (hi == opdec_pkg::HI_RMW_ACC) begin
                d_mode = opdec_pkg::MODE_ACC; // RULE_08
                d_cycles = opdec_pkg::CYC_RMW_REG;
            end else if (hi == opdec_pkg::HI_RMW_INDEX) begin
                d_mode = opdec_pkg::MODE_INDEX; // RULE_08
                d_cycles = opdec_pkg::CYC_RMW_REG;
            end else if (hi == opdec_pkg::HI_RMW_DIRECT) begin
                d_mode = opdec_pkg::MODE_DIRECT; // RULE_08
                d_bytes = opdec_pkg::LEN_2;
                d_cycles = opdec_pkg::CYC_RMW_DIR;
            end else if (hi == opdec_pkg::HI_RMW_IX) begin
                d_mode = opdec_pkg::MODE_IX; // RULE_08
                d_cycles = opdec_pkg::CYC_RMW_IX;
            end else begin
                d_mode = opdec_pkg::MODE_IX1; // RULE_08
                d_bytes = opdec_pkg::LEN_2;
                d_cycles = opdec_pkg::CYC_RMW_IX1;
            end
            // Operation from the low nibble.
            case (lo)
                opdec_pkg::LO_NEGATE: d_alu = opdec_pkg::negate_op; // RULE_09
                opdec_pkg::LO_INVERT: d_alu = opdec_pkg::complement_op; // RULE_09
                opdec_pkg::LO_SHR: d_alu = opdec_pkg::logical_shift_right_op; // RULE_09
                opdec_pkg::LO_ROTR: d_alu = opdec_pkg::rotate_right_op; // RULE_09
                opdec_pkg::LO_SAR: d_alu = opdec_pkg::arith_shift_right_op; // RULE_09
                opdec_pkg::LO_SHL: d_alu = opdec_pkg::shift_left_op; // RULE_09
                opdec_pkg::LO_ROTL: d_alu = opdec_pkg::rotate_left_op; // RULE_09
                opdec_pkg::LO_DECR: d_alu = opdec_pkg::decrement_op; // RULE_09
                opdec_pkg::LO_INC: d_alu = opdec_pkg::increment_op; // RULE_09
                opdec_pkg::LO_ZERO: d_alu = opdec_pkg::clear_op; // RULE_09
                opdec_pkg::LO_TEST: d_alu = opdec_pkg::test_value_op; // RULE_10
                default: d_legal = 1'b0;
            endcase
            // The test only reads memory, so it skips the write-back cycle.
            if (lo == opdec_pkg::LO_TEST && d_mode != opdec_pkg::MODE_ACC
                    && d_mode != opdec_pkg::MODE_INDEX) begin
                d_cycles = d_cycles - opdec_pkg::TEST_SAVING; // RULE_10
            end
        end else if (OPCODE == opdec_pkg::OP_CALL) begin
            d_group = opdec_pkg::GRP_CALL; // RULE_14
            d_mode = opdec_pkg::MODE_REL;
            d_bytes = opdec_pkg::LEN_2; // RULE_14
            d_cycles = opdec_pkg::CYC_CALL; // RULE_14
        end else begin
            case (OPCODE)
                opdec_pkg::OP_A2X: d_ctrl = opdec_pkg::acc_to_index_op; // RULE_11
                opdec_pkg::OP_X2A: d_ctrl = opdec_pkg::index_to_acc_op; // RULE_11
                opdec_pkg::OP_CSET: d_ctrl = opdec_pkg::set_carry_op; // RULE_11
                opdec_pkg::OP_CCLR: d_ctrl = opdec_pkg::clear_carry_op; // RULE_11
                opdec_pkg::OP_MSET: d_ctrl = opdec_pkg::set_mask_op; // RULE_11
                opdec_pkg::OP_MCLR: d_ctrl = opdec_pkg::clear_mask_op; // RULE_11
                opdec_pkg::OP_SPRST: d_ctrl = opdec_pkg::stack_pointer_reset_op; // RULE_11
                opdec_pkg::OP_IDLE: d_ctrl = opdec_pkg::no_operation_op; // RULE_11
                opdec_pkg::OP_STOP: d_ctrl = opdec_pkg::stop_op; // RULE_11
                opdec_pkg::OP_WAIT: d_ctrl = opdec_pkg::wait_op; // RULE_11
                opdec_pkg::OP_TRAP: begin
                    d_ctrl = opdec_pkg::soft_interrupt_op;
                    d_cycles = opdec_pkg::CYC_TRAP; // RULE_12
                end
                opdec_pkg::OP_RTS: begin
                    d_ctrl = opdec_pkg::subroutine_return_op;
                    d_cycles = opdec_pkg::CYC_RTS; // RULE_12
                end
                opdec_pkg::OP_IRET: begin
                    d_ctrl = opdec_pkg::interrupt_return_op;
                    d_cycles = opdec_pkg::CYC_IRET; // RULE_12
                end
                default: d_legal = 1'b0;
            endcase
        end
        // Opcodes outside this block's groups are flagged and take no cycles.
        if (!d_legal) begin
            d_bytes = opdec_pkg::LEN_NONE;
            d_cycles = opdec_pkg::CYC_NONE;
            d_group = opdec_pkg::GRP_NONE;
            d_alu = opdec_pkg::alu_none;
            d_ctrl = opdec_pkg::ctrl_none;
            d_mode = opdec_pkg::MODE_NONE;
        end
    end

    // The accept cycle is the first execution cycle, so the counter holds the rest.
    assign load_value = d_cycles - opdec_pkg::CYC_ONE;

    // Latch the decode on acceptance and resolve bit-test branches when the byte arrives.
    always_comb begin
        next_cur = cur;
        if (accept) begin
            next_cur.phase = d_legal ? ST_EXEC : ST_IDLE;
            next_cur.illegal = !d_legal;
            next_cur.bytes = d_bytes;
            next_cur.cycles = d_cycles;
            next_cur.group = d_group;
            next_cur.alu_op = d_alu;
            next_cur.ctrl_op = d_ctrl;
            next_cur.mode = d_mode;
            next_cur.bit_index = OPCODE[3:1]; // RULE_06 RULE_07
            next_cur.bit_value = !OPCODE[0]; // RULE_06 RULE_07
            next_cur.push_return = (d_group == opdec_pkg::GRP_CALL); // RULE_14
            if (d_group == opdec_pkg::GRP_BRANCH) begin
                next_cur.taken = d_cond;
            end else begin
                next_cur.taken = (d_group == opdec_pkg::GRP_CALL); // RULE_14
            end
            if (d_group == opdec_pkg::GRP_MULT) begin
                next_cur.product = 16'(INDEX_IN) * 16'(ACC_IN); // RULE_13
            end
        end else begin
            case (cur.phase)
                ST_EXEC: begin
                    if (TEST_BYTE_VALID && cur.group == opdec_pkg::GRP_BIT_TEST) begin
                        next_cur.taken = (TEST_BYTE[cur.bit_index] == cur.bit_value); // RULE_06
                    end
                    if (counter_last || counter_idle) begin
                        next_cur.phase = ST_IDLE;
                    end
                end
                default: next_cur.phase = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            cur <= '{phase: ST_IDLE, group: opdec_pkg::GRP_NONE,
                alu_op: opdec_pkg::alu_none, ctrl_op: opdec_pkg::ctrl_none,
                mode: opdec_pkg::MODE_NONE, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    cycle_counter #(
        .WIDTH(opdec_pkg::CYC_W)
    ) u_cycle_counter (
        .MCLK(MCLK),
        .NRST(NRST),
        .load(accept && d_legal),
        .load_value(load_value),
        .idle(counter_idle),
        .last(counter_last)
    );

    // Handshake is combinational; everything else comes from the state register.
    assign READY = counter_idle;
    assign DONE = counter_last;
    assign ILLEGAL = cur.illegal;
    assign INSTR_BYTES = cur.bytes;
    assign INSTR_CYCLES = cur.cycles;
    assign GROUP = cur.group;
    assign ALU_OP = cur.alu_op;
    assign CTRL_OP = cur.ctrl_op;
    assign OPERAND_MODE = cur.mode;
    assign BIT_INDEX = cur.bit_index;
    assign BIT_VALUE = cur.bit_value;
    assign BRANCH_TAKEN = cur.taken;
    assign PUSH_RETURN = cur.push_return;
    assign PRODUCT = cur.product;
endmodule
`default_nettype wire

//--- opcode_decode_assertions.sv
// Concurrent checks on the ports of the opcode decode and timing block.
`timescale 1ns/10ps
`default_nettype none
module opdec_checker (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic OPCODE_VALID,
    input wire logic [7:0] OPCODE,
    input wire logic FLAG_C,
    input wire logic READY,
    input wire logic DONE,
    input wire logic [opdec_pkg::LEN_W-1:0] INSTR_BYTES,
    input wire logic [opdec_pkg::CYC_W-1:0] INSTR_CYCLES,
    input wire logic BRANCH_TAKEN,
    input wire logic PUSH_RETURN
);
    default clocking dc @(posedge MCLK);
    endclocking
    default disable iff (!NRST);
    logic acc;
    // An opcode is taken when it is offered while the block is free.
    assign acc = OPCODE_VALID && READY;
    branch_len_a: assert property (acc && OPCODE[7:4] == 4'h2 |=> INSTR_BYTES == 2'h2)
        else $error("branch length wrong");
    branch_time_a: assert property (acc && OPCODE[7:4] == 4'h2 |=>
        !READY ##1 DONE ##1 READY) else $error("branch timing wrong");
    carry_set_a: assert property (acc && OPCODE == 8'h25 |=>
        BRANCH_TAKEN == $past(FLAG_C)) else $error("carry branch decision wrong");
    done_pulse_a: assert property (DONE |=> READY && !DONE)
        else $error("done longer than one cycle");
    bit_test_a: assert property (acc && OPCODE[7:4] == 4'h0 |=>
        INSTR_BYTES == 2'h3 ##3 DONE) else $error("bit test timing wrong");
    bit_set_a: assert property (acc && OPCODE[7:4] == 4'h1 |=>
        INSTR_BYTES == 2'h2 ##3 DONE) else $error("bit set timing wrong");
    test_offset_a: assert property (acc && OPCODE == 8'h6d |=>
        INSTR_CYCLES == 4'h5 ##3 DONE) else $error("test timing wrong");
    no_op_time_a: assert property (acc && OPCODE == 8'h9d |=>
        INSTR_CYCLES == 4'h2 && DONE) else $error("control timing wrong");
    soft_int_time_a: assert property (acc && OPCODE == 8'h83 |=>
        !READY [*8] ##1 DONE) else $error("soft interrupt timing wrong");
    multiply_time_a: assert property (acc && OPCODE == 8'h42 |=>
        !DONE [*8] ##1 !DONE ##1 DONE) else $error("multiply timing wrong");
    call_push_a: assert property (acc && OPCODE == 8'had |=> PUSH_RETURN && BRANCH_TAKEN)
        else $error("call decode wrong");
    // Main scenarios reached.
    cover property (acc && OPCODE == 8'h83);
    cover property (acc && OPCODE == 8'had);
    cover property (acc && OPCODE[7:4] == 4'h0);
endmodule
bind opcode_decode opdec_checker chk_u (.MCLK(MCLK), .NRST(NRST), .OPCODE_VALID(OPCODE_VALID),
    .OPCODE(OPCODE), .FLAG_C(FLAG_C), .READY(READY), .DONE(DONE), .INSTR_BYTES(INSTR_BYTES),
    .INSTR_CYCLES(INSTR_CYCLES), .BRANCH_TAKEN(BRANCH_TAKEN), .PUSH_RETURN(PUSH_RETURN));
`default_nettype wire

//--- opcode_decode_tb.sv
// Self-checking bench for the opcode decode and timing block.
`timescale 1ns/10ps
`default_nettype none
module opcode_decode_tb;
    logic MCLK = 1'b0;
    logic NRST = 1'b0;
    logic OPCODE_VALID = 1'b0;
    logic [7:0] OPCODE = 8'h00;
    logic [5:0] f = 6'h00; // Carry, zero, half carry, negative, mask, interrupt line.
    logic TEST_BYTE_VALID = 1'b0;
    logic [7:0] TEST_BYTE = 8'h00;
    logic [7:0] INDEX_IN = 8'h00;
    logic [7:0] ACC_IN = 8'h00;
    logic READY, DONE, ILLEGAL, BIT_VALUE, BRANCH_TAKEN, PUSH_RETURN;
    logic [1:0] INSTR_BYTES;
    logic [3:0] INSTR_CYCLES, ALU_OP, CTRL_OP;
    logic [2:0] GROUP, OPERAND_MODE, BIT_INDEX;
    logic [15:0] PRODUCT;
    int failures = 0;
    int checks_done = 0;

    opcode_decode dut_u (.MCLK(MCLK), .NRST(NRST), .OPCODE_VALID(OPCODE_VALID), .OPCODE(OPCODE),
        .FLAG_H(f[2]), .FLAG_I(f[4]), .FLAG_N(f[3]), .FLAG_Z(f[1]), .FLAG_C(f[0]),
        .IRQ_LINE(f[5]),
        .TEST_BYTE_VALID(TEST_BYTE_VALID), .TEST_BYTE(TEST_BYTE), .INDEX_IN(INDEX_IN),
        .ACC_IN(ACC_IN), .READY(READY), .DONE(DONE), .ILLEGAL(ILLEGAL),
        .INSTR_BYTES(INSTR_BYTES), .INSTR_CYCLES(INSTR_CYCLES), .GROUP(GROUP), .ALU_OP(ALU_OP),
        .CTRL_OP(CTRL_OP), .OPERAND_MODE(OPERAND_MODE), .BIT_INDEX(BIT_INDEX),
        .BIT_VALUE(BIT_VALUE), .BRANCH_TAKEN(BRANCH_TAKEN), .PUSH_RETURN(PUSH_RETURN),
        .PRODUCT(PRODUCT));

    // Clock of 8 ns period.
    always #4 MCLK = ~MCLK;

    // Counts a comparison and reports it when it fails.
    task chk(input bit ok, input string msg);
        checks_done++;
        if (!ok) begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task give_verdict;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Offers one opcode, checks length and the cycle of the done pulse, then readiness.
    task exec(input logic [7:0] op, input logic [1:0] nb, input logic [3:0] nc,
        input logic [5:0] fl);
        int k;
        @(posedge MCLK);
        OPCODE <= op;
        OPCODE_VALID <= 1'b1;
        f <= fl;
        @(posedge MCLK);
        OPCODE_VALID <= 1'b0;
        #1;
        chk(INSTR_BYTES === nb && INSTR_CYCLES === nc && ILLEGAL === 1'b0, "length");
        k = 1;
        while (DONE !== 1'b1 && k < 16) begin
            @(posedge MCLK);
            #1;
            k++;
        end
        if (k == 16) begin
            failures++;
            give_verdict();
        end
        chk(k == int'(nc) - 1, "done cycle");
        @(posedge MCLK);
        #1;
        chk(READY === 1'b1, "ready after done");
    endtask

    // Every relative branch with each flag high alone, then with all flags low.
    task branch_test;
        logic v;
        for (int s = 0; s < 7; s++) begin
            for (int lo = 0; lo < 16; lo++) begin
                exec({4'h2, 4'(lo)}, 2'h2, 4'h3, 6'(1 << s));
                v = (lo < 2) ? !lo[0] : (lo[0] == ((lo < 4) ? (f[0] || f[1]) : f[lo / 2 - 2]));
                chk(BRANCH_TAKEN === v, "branch");
                chk(OPERAND_MODE === 3'h6 && GROUP === 3'h1, "branch mode");
            end
        end
    endtask

    // Bit tests on a byte with only the tested bit set, and bit set or clear.
    task bit_test;
        for (int n = 0; n < 16; n++) begin
            @(posedge MCLK);
            TEST_BYTE <= 8'h01 << n[3:1];
            TEST_BYTE_VALID <= 1'b1;
            exec(8'(n), 2'h3, 4'h5, '0);
            chk(BRANCH_TAKEN === !n[0] && BIT_INDEX === n[3:1], "bit test");
            exec(8'h10 + 8'(n), 2'h2, 4'h5, '0);
            chk(BIT_VALUE === !n[0] && GROUP === 3'h3, "bit set");
        end
    endtask

    // Every read/modify/write operation in every operand form.
    task rmw_test;
        logic [3:0] lo_tab [11] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc,
            4'hd, 4'hf};
        logic [3:0] cy_tab [5] = '{4'h5, 4'h3, 4'h3, 4'h6, 4'h5};
        logic [2:0] md_tab [5] = '{3'h3, 3'h1, 3'h2, 3'h5, 3'h4};
        logic [3:0] nc;
        for (int h = 0; h < 5; h++) begin
            for (int i = 0; i < 11; i++) begin
                nc = cy_tab[h] - ((i == 9 && h != 1 && h != 2) ? 4'h1 : 4'h0);
                exec({4'(h + 3), lo_tab[i]}, (h == 0 || h == 3) ? 2'h2 : 2'h1,
                    nc, '0);
                chk(ALU_OP === 4'(i + 1) && OPERAND_MODE === md_tab[h], "rmw");
            end
        end
    endtask

    // Every control opcode.
    task ctrl_test;
        logic [7:0] op_tab [13] = '{8'h97, 8'h9f, 8'h99, 8'h98, 8'h9b, 8'h9a, 8'h83,
            8'h81, 8'h80, 8'h9c, 8'h9d, 8'h8e, 8'h8f};
        for (int i = 0; i < 13; i++) begin
            exec(op_tab[i], 2'h1, (i == 6) ? 4'ha : (i == 7) ? 4'h6 :
                (i == 8) ? 4'h9 : 4'h2, '0);
            chk(CTRL_OP === 4'(i + 1), "control");
        end
    endtask

    // Multiply of FE by FF, relative call, then an opcode outside this block.
    task misc_test;
        @(posedge MCLK);
        INDEX_IN <= 8'hfe;
        ACC_IN <= 8'hff;
        exec(8'h42, 2'h1, 4'hb, '0);
        chk(PRODUCT === 16'hfd02 && ALU_OP === 4'hc, "multiply");
        exec(8'had, 2'h2, 4'h6, '0);
        chk(PUSH_RETURN === 1'b1 && BRANCH_TAKEN === 1'b1, "call");
        @(posedge MCLK);
        OPCODE <= 8'h41;
        OPCODE_VALID <= 1'b1;
        @(posedge MCLK);
        OPCODE_VALID <= 1'b0;
        #1;
        chk(ILLEGAL === 1'b1 && READY === 1'b1 && INSTR_CYCLES === 4'h0, "illegal");
    endtask

    // Reset, then the scenarios in turn.
    initial begin
        repeat (3) @(posedge MCLK);
        NRST <= 1'b1;
        #1;
        chk(READY === 1'b1 && DONE === 1'b0 && GROUP === 3'h0, "reset");
        branch_test();
        bit_test();
        rmw_test();
        ctrl_test();
        misc_test();
        give_verdict();
    end
endmodule
`default_nettype wire
